// ==== bci_alu.sv ====
// bci_alu: combinational result and flag logic for the subset
// assumes: operands are stable for the issue cycle
`timescale 1ns/1ps
`default_nettype none
module bci_alu
  import bci_pkg::*;
(
  // operation
  input wire bci_pkg::bci_op_e op,
  input wire logic [7:0] lit,
  // operands
  input wire logic [7:0] acc,
  input wire logic [7:0] fval,
  input wire bci_pkg::bci_flags_s flags_in,
  // results
  output logic [7:0] result,
  output bci_pkg::bci_flags_s flags_out
);
  // ****************************************
  // subtract, rotate, swap and xor results
  // ****************************************
  // minuend is the literal or the file value; carry out of the adder is the no-borrow flag
  wire logic [7:0] minuend = (op == BCI_OP_LIT_SUB) ? lit : fval;
  wire logic [8:0] diff = {1'b0, minuend} + {1'b0, ~acc} + 9'h001;
  wire logic [4:0] ndiff = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  wire logic [7:0] rot = {flags_in.carry, fval[7:1]};
  wire logic [7:0] swp = {fval[3:0], fval[7:4]};
  wire logic [7:0] xf = acc ^ fval;
  wire logic [7:0] xl = acc ^ lit;
  wire logic is_sub = (op == BCI_OP_LIT_SUB) || (op == BCI_OP_FILE_SUB);
  wire logic is_xor = (op == BCI_OP_FILE_XOR) || (op == BCI_OP_LIT_XOR);

  assign result = is_sub ? diff[7:0] :
                  (op == BCI_OP_ROTR) ? rot :
                  (op == BCI_OP_NIB_XCHG) ? swp :
                  (op == BCI_OP_FILE_XOR) ? xf :
                  (op == BCI_OP_LIT_XOR) ? xl : acc;

  // ****************************************
  // flags
  // ****************************************
  assign flags_out.carry = is_sub ? diff[8] :
                           (op == BCI_OP_ROTR) ? fval[0] : flags_in.carry;
  assign flags_out.nib_borrow = is_sub ? ndiff[4] : flags_in.nib_borrow;
  assign flags_out.zero = (is_sub || is_xor) ? (result == 8'h00) : flags_in.zero;
endmodule
`default_nettype wire

// ==== bci_core.sv ====
// bci_core: execution of the halt, return, rotate, subtract, swap and xor subset
// assumes: decoder issues one instruction per issue pulse while ready is high;
// file register read data is combinational on faddr; the stack pops on pop pulse
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bci_core
  import bci_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // instruction issue
  input wire logic issue,
  input wire bci_pkg::bci_instr_s instr,
  output logic ready,
  // file registers
  output logic [6:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic file_we,
  output logic [7:0] file_wdata,
  // return stack
  input wire logic [12:0] stack_top_entry,
  output logic stack_pop,
  output logic pc_load,
  output logic [12:0] pc_value,
  // architectural state
  output logic [7:0] acc,
  output bci_pkg::bci_flags_s flags,
  output logic watchdog_expiry_flag_n,
  output logic power_down_flag_n,
  output logic [7:0] watchdog_counter,
  output logic [7:0] watchdog_prescaler,
  output logic halted,
  output logic osc_run
);
  import bci_pkg::*;

  // ****************************************
  // sequencing
  // ****************************************
  typedef enum logic [1:0] {
    BCI_ST_RUN = 2'b00,
    BCI_ST_RET2 = 2'b01,
    BCI_ST_HALT = 2'b10
  } bci_state_e;

  bci_state_e st_r;
  bci_state_e st_nxt;
  logic [7:0] acc_r;
  bci_flags_s flags_r;
  logic exp_n_r;
  logic pdown_n_r;
  logic [7:0] wdog_r;
  logic [7:0] pre_r;
  // status outputs are registered copies of the next state, so ports come from flops
  logic rdy_r;
  logic hlt_r;
  logic osc_r;
  logic fwe_r;
  logic [7:0] fwd_r;
  logic [6:0] fad_r;
  logic pop_r;
  logic pcl_r;
  logic [12:0] pcv_r;

  // only the run state accepts work; halt is final until reset
  wire logic go = issue && (st_r == BCI_ST_RUN);
  wire logic do_halt = go && (instr.op == BCI_OP_HALT);
  wire logic do_ret = go && (instr.op == BCI_OP_SUB_EXIT);
  wire logic dest_sel = (instr.op == BCI_OP_ROTR) || (instr.op == BCI_OP_FILE_SUB) ||
                        (instr.op == BCI_OP_NIB_XCHG) || (instr.op == BCI_OP_FILE_XOR);
  wire logic to_file = dest_sel && (instr.dest == BCI_DEST_FILE);
  wire logic to_acc = (dest_sel && (instr.dest == BCI_DEST_ACC)) ||
                      (instr.op == BCI_OP_LIT_SUB) || (instr.op == BCI_OP_LIT_XOR);
  wire logic alu_op = dest_sel || (instr.op == BCI_OP_LIT_SUB) || (instr.op == BCI_OP_LIT_XOR);
  wire logic [7:0] alu_res;
  bci_flags_s alu_flags;

  bci_alu u_alu (
    .op(instr.op),
    .lit(instr.lit),
    .acc(acc_r),
    .fval(file_rdata),
    .flags_in(flags_r),
    .result(alu_res),
    .flags_out(alu_flags)
  );

  always_comb begin
    case (st_r)
      BCI_ST_RUN: begin
        if (do_halt) begin
          st_nxt = BCI_ST_HALT;
        end else if (do_ret) begin
          st_nxt = BCI_ST_RET2;
        end else begin
          st_nxt = BCI_ST_RUN;
        end
      end
      BCI_ST_RET2: st_nxt = BCI_ST_RUN;
      BCI_ST_HALT: st_nxt = BCI_ST_HALT;
      default: st_nxt = BCI_ST_RUN;
    endcase
  end

  // ****************************************
  // state registers
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= BCI_ST_RUN;
      rdy_r <= BCI_READY_RST;
      hlt_r <= BCI_HALTED_RST;
      osc_r <= !BCI_HALTED_RST;
    end else begin
      st_r <= st_nxt;
      rdy_r <= (st_nxt == BCI_ST_RUN);
      hlt_r <= (st_nxt == BCI_ST_HALT);
      osc_r <= (st_nxt != BCI_ST_HALT);
    end
  end

  // accumulator and flags; flags untouched by exit, halt and swap
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_r <= BCI_ACC_RST;
      flags_r <= '0;
    end else if (go && alu_op) begin
      if (to_acc) begin
        acc_r <= alu_res;
      end
      flags_r <= alu_flags;
    end
  end

  // watchdog clear and status bits on halt
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdog_r <= BCI_WDOG_CLEAR;
      pre_r <= BCI_PRE_CLEAR;
      exp_n_r <= BCI_EXPIRY_N_RST;
      pdown_n_r <= BCI_PDOWN_N_RST;
    end else if (do_halt) begin
      wdog_r <= BCI_WDOG_CLEAR;
      pre_r <= BCI_PRE_CLEAR;
      exp_n_r <= 1'b1;
      pdown_n_r <= 1'b0;
    end
  end

  // file write-back and stack pop, each a one-cycle pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fwe_r <= 1'b0;
      fwd_r <= 8'h00;
      fad_r <= 7'h00;
      pop_r <= 1'b0;
      pcl_r <= 1'b0;
      pcv_r <= 13'h0000;
    end else begin
      fwe_r <= go && to_file;
      fwd_r <= alu_res;
      fad_r <= instr.faddr;
      pop_r <= do_ret;
      pcl_r <= do_ret;
      if (do_ret) begin
        pcv_r <= stack_top_entry;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // file_addr is the live read address so the operand arrives in the issue cycle
  assign file_addr = (st_r == BCI_ST_RUN) ? instr.faddr : fad_r;
  assign ready = rdy_r;
  assign file_we = fwe_r;
  assign file_wdata = fwd_r;
  assign stack_pop = pop_r;
  assign pc_load = pcl_r;
  assign pc_value = pcv_r;
  assign acc = acc_r;
  assign flags = flags_r;
  assign watchdog_expiry_flag_n = exp_n_r;
  assign power_down_flag_n = pdown_n_r;
  assign watchdog_counter = wdog_r;
  assign watchdog_prescaler = pre_r;
  assign halted = hlt_r;
  assign osc_run = osc_r;
endmodule
`default_nettype wire

// ==== bci_core_props.sv ====
// bci_core_props: concurrent checks on the bci_core ports
// assumes: one clock clk, asynchronous active-low resetn
`timescale 1ns/1ps
`default_nettype none
module bci_core_props
  import bci_pkg::*;
(
  // watched core ports
  input wire logic clk,
  input wire logic resetn,
  input wire logic issue,
  input wire bci_pkg::bci_instr_s instr,
  input wire logic ready,
  input wire logic file_we,
  input wire logic [12:0] stack_top_entry,
  input wire logic stack_pop,
  input wire logic pc_load,
  input wire logic [12:0] pc_value,
  input wire logic [7:0] acc,
  input wire bci_pkg::bci_flags_s flags,
  input wire logic watchdog_expiry_flag_n,
  input wire logic power_down_flag_n,
  input wire logic [7:0] watchdog_counter,
  input wire logic [7:0] watchdog_prescaler,
  input wire logic halted,
  input wire logic osc_run
);
  // ****
  // properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic go = issue & ready;
  wire logic hlt = go & (instr.op == BCI_OP_HALT);
  wire logic ex = go & (instr.op == BCI_OP_SUB_EXIT);
  wire logic sw = go & (instr.op == BCI_OP_NIB_XCHG);
  wire logic lx = go & (instr.op == BCI_OP_LIT_XOR);
  wire logic fop = (instr.op == BCI_OP_ROTR) | (instr.op == BCI_OP_FILE_SUB) |
                   (instr.op == BCI_OP_NIB_XCHG) | (instr.op == BCI_OP_FILE_XOR);
  wire logic fdst = go & fop & (instr.dest == BCI_DEST_FILE);
  property p_hclr; hlt |=> (watchdog_counter | watchdog_prescaler) == 8'h00; endproperty
  a_hclr: assert property (p_hclr) else $error("halt kept watchdog count");
  property p_hst; hlt |=> watchdog_expiry_flag_n && !power_down_flag_n; endproperty
  a_hst: assert property (p_hst) else $error("halt status bits wrong");
  property p_hold; halted |=> halted && !ready && !osc_run; endproperty
  a_hold: assert property (p_hold) else $error("halt state left");
  property p_pop; ex |=> stack_pop && pc_load && pc_value == $past(stack_top_entry) && flags == $past(flags); endproperty
  a_pop: assert property (p_pop) else $error("exit pop wrong");
  property p_two; ex |=> !ready ##1 ready; endproperty
  a_two: assert property (p_two) else $error("exit length wrong");
  property p_swp; sw |=> flags == $past(flags); endproperty
  a_swp: assert property (p_swp) else $error("exchange moved flags");
  property p_lx; lx |=> acc == ($past(acc) ^ $past(instr.lit)); endproperty
  a_lx: assert property (p_lx) else $error("literal xor wrong");
  property p_z; lx |=> flags.zero == (acc == 8'h00); endproperty
  a_z: assert property (p_z) else $error("zero flag wrong");
  property p_fwe; fdst |=> file_we && acc == $past(acc); endproperty
  a_fwe: assert property (p_fwe) else $error("file destination not written");
  property p_fsrc; file_we |-> $past(fdst); endproperty
  a_fsrc: assert property (p_fsrc) else $error("file write without file destination");
  c_halt: cover property (hlt);
  c_exit: cover property (ex);
  c_fw: cover property (file_we);
endmodule
bind bci_core bci_core_props u_props (.clk, .resetn, .issue, .instr, .ready, .file_we, .stack_top_entry,
  .stack_pop, .pc_load, .pc_value, .acc, .flags, .watchdog_expiry_flag_n, .power_down_flag_n,
  .watchdog_counter, .watchdog_prescaler, .halted, .osc_run);
`default_nettype wire

// ==== bci_pkg.sv ====
// bci_pkg: constants, opcodes and carriers for the byte core execution subset
// assumes: one core clock, decoder supplies one instruction per issue pulse
package bci_pkg;

  // ****************************************
  // opcodes
  // ****************************************
  typedef enum logic [3:0] {
    BCI_OP_NONE     = 4'h0,
    BCI_OP_HALT     = 4'h1,
    BCI_OP_SUB_EXIT = 4'h2,
    BCI_OP_ROTR     = 4'h3,
    BCI_OP_LIT_SUB  = 4'h4,
    BCI_OP_FILE_SUB = 4'h5,
    BCI_OP_NIB_XCHG = 4'h6,
    BCI_OP_FILE_XOR = 4'h7,
    BCI_OP_LIT_XOR  = 4'h8
  } bci_op_e;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int BCI_DW = 8;
  localparam int BCI_FADDR_W = 7;
  localparam int BCI_PC_W = 13;
  localparam int BCI_WDOG_W = 8;
  localparam int BCI_PRE_W = 8;
  localparam logic [7:0] BCI_WDOG_CLEAR = 8'h00;
  localparam logic [7:0] BCI_PRE_CLEAR = 8'h00;
  localparam logic [7:0] BCI_ACC_RST = 8'h00;
  localparam logic BCI_EXPIRY_N_RST = 1'b1;
  localparam logic BCI_PDOWN_N_RST = 1'b1;
  localparam logic BCI_READY_RST = 1'b1;
  localparam logic BCI_HALTED_RST = 1'b0;
  localparam logic BCI_DEST_ACC = 1'b0;
  localparam logic BCI_DEST_FILE = 1'b1;
  localparam int BCI_RET_CYCLES = 2;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    bci_op_e op;
    logic dest;
    logic [6:0] faddr;
    logic [7:0] lit;
  } bci_instr_s;

  typedef struct packed {
    logic carry;
    logic nib_borrow;
    logic zero;
  } bci_flags_s;

endpackage

// ==== tb_top.sv ====
// tb_top: self-checking bench for bci_core
// assumes: bci_pkg and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bci_pkg::*;
  // ****
  // bench
  // ****
  logic clk, resetn, issue, ready, file_we, stack_pop, pc_load, halted, osc_run;
  logic watchdog_expiry_flag_n, power_down_flag_n;
  logic [6:0] file_addr;
  logic [7:0] file_rdata, file_wdata, acc, watchdog_counter, watchdog_prescaler, m_acc;
  logic [12:0] stack_top_entry, pc_value;
  bci_instr_s instr;
  bci_flags_s flags, m_fl;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  bci_core dut (.clk, .resetn, .issue, .instr, .ready, .file_addr, .file_rdata, .file_we, .file_wdata,
    .stack_top_entry, .stack_pop, .pc_load, .pc_value, .acc, .flags, .watchdog_expiry_flag_n,
    .power_down_flag_n, .watchdog_counter, .watchdog_prescaler, .halted, .osc_run);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(string nm, logic [12:0] seen, logic [12:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    m_acc = 8'h00;
    m_fl = '0;
    #1;
    chk("acc", 13'(acc), 13'h0000);
    chk("state", 13'({ready, halted, watchdog_expiry_flag_n, power_down_flag_n, 3'(flags)}), 13'h0058);
  endtask
  // inverse data after issue so a late sample cannot pass by luck
  task automatic send(bci_op_e op, logic d, logic [7:0] f, logic [7:0] k);
    @(posedge clk);
    issue <= 1'b1;
    instr <= '{op, d, {3'h5, op}, k};
    file_rdata <= f;
    @(posedge clk);
    issue <= 1'b0;
    file_rdata <= ~f;
    #1;
  endtask
  task automatic alu(bci_op_e op, logic d, logic [7:0] f, logic [7:0] k);
    logic [7:0] r, s;
    logic lit, wr;
    lit = op == BCI_OP_LIT_SUB || op == BCI_OP_LIT_XOR;
    s = lit ? k : f;
    r = (op == BCI_OP_LIT_XOR || op == BCI_OP_FILE_XOR) ? s ^ m_acc : s - m_acc;
    if (op == BCI_OP_LIT_SUB || op == BCI_OP_FILE_SUB) begin
      m_fl.carry = s >= m_acc;
      m_fl.nib_borrow = s[3:0] >= m_acc[3:0];
    end
    if (op == BCI_OP_ROTR) begin
      r = {m_fl.carry, f[7:1]};
      m_fl.carry = f[0];
    end
    if (op == BCI_OP_NIB_XCHG)
      r = {f[3:0], f[7:4]};
    else if (op != BCI_OP_ROTR)
      m_fl.zero = r == 8'h00;
    wr = d && !lit;
    if (!wr)
      m_acc = r;
    send(op, d, f, k);
    chk("acc", 13'(acc), 13'(m_acc));
    chk("flags", 13'(flags), 13'(m_fl));
    chk("file_we", 13'(file_we), 13'(wr));
    if (wr) begin
      chk("file_wdata", 13'(file_wdata), 13'(r));
      chk("file_addr", 13'(file_addr), 13'({3'h5, op}));
    end
  endtask
  task automatic t_alu();
    alu(BCI_OP_LIT_XOR, 1'b1, 8'h00, 8'ha5);
    alu(BCI_OP_LIT_SUB, 1'b0, 8'h00, 8'h05);
    alu(BCI_OP_FILE_SUB, 1'b1, 8'h60, 8'h00);
    alu(BCI_OP_FILE_SUB, 1'b0, 8'h5f, 8'h00);
    alu(BCI_OP_ROTR, 1'b0, 8'h81, 8'h00);
    alu(BCI_OP_ROTR, 1'b1, 8'h02, 8'h00);
    alu(BCI_OP_NIB_XCHG, 1'b1, 8'h3c, 8'h00);
    alu(BCI_OP_NIB_XCHG, 1'b0, 8'hc3, 8'h00);
    alu(BCI_OP_FILE_XOR, 1'b1, 8'h3c, 8'h00);
    alu(BCI_OP_FILE_XOR, 1'b0, 8'h0f, 8'h00);
    alu(BCI_OP_LIT_XOR, 1'b0, 8'h00, 8'h33);
    $display("t_alu done");
  endtask
  // second instruction rides the dead cycle and must be dropped
  task automatic t_exit();
    @(posedge clk);
    stack_top_entry <= 13'h1abc;
    issue <= 1'b1;
    instr <= '{BCI_OP_SUB_EXIT, 1'b0, 7'h00, 8'h00};
    @(posedge clk);
    instr <= '{BCI_OP_LIT_XOR, 1'b0, 7'h00, 8'hff};
    #1;
    chk("exit", 13'({stack_pop, pc_load, ready}), 13'h0006);
    chk("pc", pc_value, 13'h1abc);
    chk("flags", 13'(flags), 13'(m_fl));
    @(posedge clk);
    issue <= 1'b0;
    #1;
    chk("after", 13'({stack_pop, pc_load, ready, acc}), 13'(m_acc) | 13'h0100);
    $display("t_exit done");
  endtask
  task automatic t_halt();
    send(BCI_OP_HALT, 1'b0, 8'h00, 8'h00);
    chk("halt", 13'({halted, osc_run, ready, watchdog_expiry_flag_n, power_down_flag_n}), 13'h0012);
    chk("wdog", 13'(watchdog_counter | watchdog_prescaler), 13'h0000);
    send(BCI_OP_LIT_XOR, 1'b0, 8'h00, 8'hff);
    chk("held", 13'({halted, acc}), 13'(m_acc) | 13'h0100);
    do_reset();
    $display("t_halt done");
  endtask
  initial begin
    resetn = 1'b0;
    issue = 1'b0;
    instr = '0;
    file_rdata = 8'h00;
    stack_top_entry = 13'h0000;
    do_reset();
    t_alu();
    t_exit();
    t_halt();
    tally_and_finish();
  end
endmodule
`default_nettype wire
